// ### common/tps_pkg.sv
// Constants, register map and types shared by the two-port parity memory block.
package tps_pkg;
   // Memory geometry.
   localparam int TPS_AW      = 8;
   localparam int TPS_DW      = 9;
   localparam int TPS_DBW     = 8;
   localparam int TPS_PAR_BIT = 8;
   localparam int TPS_DEPTH   = 256;

   // APB geometry.
   localparam int TPS_PAW = 8;
   localparam int TPS_PDW = 32;

   // Register byte addresses.
   localparam logic [TPS_PAW-1:0] TPS_CTRL_OFS   = 8'h00;
   localparam logic [TPS_PAW-1:0] TPS_STATUS_OFS = 8'h04;
   localparam logic [TPS_PAW-1:0] TPS_MASK_OFS   = 8'h08;

   // Control register field positions.
   localparam int TPS_CTRL_RMODE  = 0;
   localparam int TPS_RMODE_W     = 2;
   localparam int TPS_CTRL_WASYNC = 2;
   localparam int TPS_CTRL_ODD    = 3;
   localparam int TPS_CTRL_PGEN   = 4;

   // Event bits, shared by the status and mask registers.
   localparam int TPS_STS_RPF = 0;
   localparam int TPS_STS_WPF = 1;
   localparam int TPS_NEVT    = 2;

   // Read modes.
   localparam logic [TPS_RMODE_W-1:0] TPS_RM_TRANSP  = 2'h0;
   localparam logic [TPS_RMODE_W-1:0] TPS_RM_PIPE    = 2'h1;
   localparam logic [TPS_RMODE_W-1:0] TPS_RM_ASYNC_A = 2'h2;
   localparam logic [TPS_RMODE_W-1:0] TPS_RM_ASYNC_S = 2'h3;

   // Reset values.
   localparam logic [TPS_RMODE_W-1:0] TPS_RMODE_RST  = TPS_RM_TRANSP;
   localparam logic                   TPS_WASYNC_RST = 1'h0;
   localparam logic                   TPS_ODD_RST    = 1'h0;
   localparam logic                   TPS_PGEN_RST   = 1'h0;
   localparam logic [TPS_NEVT-1:0]    TPS_MASK_RST   = 2'h0;

   typedef enum logic [1:0] {
      TPS_AP_IDLE = 2'h1,
      TPS_AP_RESP = 2'h2
   } tps_ap_state_t;
endpackage

// ### common/tps_par_if.sv
// Signals between the memory core and one parity unit.
`timescale 1ns/1ps
`default_nettype none
interface tps_par_if;
   import tps_pkg::*;
   logic [TPS_DBW-1:0] data;
   logic               stored_bit;
   logic               odd;
   logic               par_bit;
   logic               fault;

   modport unit (
      input  data,
      input  stored_bit,
      input  odd,
      output par_bit,
      output fault
   );

   modport user (
      output data,
      output stored_bit,
      output odd,
      input  par_bit,
      input  fault
   );
endinterface
`default_nettype wire

// ### verilog/tps_parity.sv
// Parity generator and checker over the eight data bits of one word.
`timescale 1ns/1ps
`default_nettype none
module tps_parity (
   tps_par_if.unit p
);
   always_comb begin
      // Odd parity makes the total count of ones, parity bit included, odd.
      p.par_bit = (^p.data) ^ p.odd;
      p.fault   = p.stored_bit ^ (^p.data) ^ p.odd;
   end
endmodule
`default_nettype wire

// ### verilog/tps_sram_core.sv
// Two-port 256 x 9 memory with parity, selectable read and write timing, APB control.
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Same-location read and write returns the write data.
// - Transparent read updates outputs at the read edge.
// - Pipelined read outputs appear after second read edge.
// - Synchronous writes follow the write port clock.
// - Synchronous reads follow the separate read clock.
// - Accept nine-bit write word, bit eight parity.
// - Return nine-bit read word, bit eight parity.
// - Read parity fault flags a failing read word.
// - Write parity fault flags failing incoming data.
// - Odd parity select high means odd, else even.
// - Address or strobe timed reads; async writes too.
// - Write parity fault held low while generating parity.
module tps_sram_core
   import tps_pkg::*;
(
   input  wire logic               core_clk,
   input  wire logic               srst,
   input  wire logic               write_port_clock,
   input  wire logic               read_port_clock,
   input  wire logic [TPS_AW-1:0]  read_address,
   input  wire logic               read_select_n,
   input  wire logic               read_strobe_n,
   input  wire logic [TPS_AW-1:0]  write_address,
   input  wire logic               write_select_n,
   input  wire logic [TPS_DW-1:0]  write_data,
   input  wire logic               write_strobe_n,
   output logic      [TPS_DW-1:0]  read_data,
   output logic                    read_parity_fault,
   output logic                    write_parity_fault,
   output logic                    irq,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [TPS_PAW-1:0] paddr,
   input  wire logic [TPS_PDW-1:0] pwdata,
   output logic      [TPS_PDW-1:0] prdata,
   output logic                    pready,
   output logic                    pslverr
);

   typedef struct packed {
      logic [TPS_DEPTH-1:0][TPS_DW-1:0] mem;
      logic [TPS_DW-1:0]                rdata;
      logic                             rpf;
      logic                             wpf;
      logic                             irq;
      logic [TPS_DW-1:0]                pipe;
      logic                             pipe_f;
      logic                             pipe_v;
      logic                             wclk_p;
      logic                             rclk_p;
      logic                             rstb_p;
      logic [TPS_RMODE_W-1:0]           rmode;
      logic                             wasync;
      logic                             odd;
      logic                             pgen;
      logic [TPS_NEVT-1:0]              sts;
      logic [TPS_NEVT-1:0]              msk;
      tps_ap_state_t                    ap;
      logic [TPS_PDW-1:0]               prdata;
      logic                             pready;
      logic                             pslverr;
   } tps_core_state_t;

   tps_core_state_t q;
   tps_core_state_t d;

   logic              wr_edge;
   logic              rd_edge;
   logic              rstb_fall;
   logic              wr_acc;
   logic              rd_acc;
   logic              wr_en;
   logic              rd_hit;
   logic              wfault;
   logic              rfault;
   logic              rd_upd;
   logic              rd_new_f;
   logic [TPS_DW-1:0] wword;
   logic [TPS_DW-1:0] rword;
   logic [TPS_DW-1:0] rd_new;

   tps_par_if wp_if ();
   tps_par_if rp_if ();

   tps_parity u_wpar (
      .p (wp_if.unit)
   );

   tps_parity u_rpar (
      .p (rp_if.unit)
   );

   // The port clocks are plain inputs sampled by core_clk; a rise is seen one core edge late.
   assign wr_edge   = write_port_clock & ~q.wclk_p;
   assign rd_edge   = read_port_clock & ~q.rclk_p;
   assign rstb_fall = ~read_strobe_n & q.rstb_p;

   assign wr_acc = ~write_select_n & ~write_strobe_n;
   assign rd_acc = ~read_select_n & ~read_strobe_n;

   // In asynchronous write mode the word is stored on every core edge of the strobe pulse.
   assign wr_en = wr_acc & (q.wasync | wr_edge);

   assign wp_if.data       = write_data[TPS_DBW-1:0];
   assign wp_if.stored_bit = write_data[TPS_PAR_BIT];
   assign wp_if.odd        = q.odd;
   assign wfault           = wp_if.fault & ~q.pgen;

   assign wword = {(q.pgen ? wp_if.par_bit : write_data[TPS_PAR_BIT]),
                   write_data[TPS_DBW-1:0]};

   // A write landing on the location being read is bypassed to the read side.
   assign rd_hit = wr_en & (write_address == read_address);
   assign rword  = rd_hit ? wword : q.mem[read_address];

   assign rp_if.data       = rword[TPS_DBW-1:0];
   assign rp_if.stored_bit = rword[TPS_PAR_BIT];
   assign rp_if.odd        = q.odd;
   assign rfault           = rp_if.fault;

   always_comb begin
      if (q.rmode == TPS_RM_TRANSP) begin
         rd_upd = rd_edge & rd_acc;
      end else if (q.rmode == TPS_RM_PIPE) begin
         rd_upd = rd_edge & q.pipe_v;
      end else if (q.rmode == TPS_RM_ASYNC_A) begin
         rd_upd = rd_acc;
      end else begin
         rd_upd = rstb_fall & ~read_select_n;
      end
   end

   assign rd_new   = (q.rmode == TPS_RM_PIPE) ? q.pipe : rword;
   assign rd_new_f = (q.rmode == TPS_RM_PIPE) ? q.pipe_f : rfault;

   always_comb begin
      logic [TPS_PDW-1:0]  rv;
      logic                map;
      logic [TPS_NEVT-1:0] clr;
      logic [TPS_NEVT-1:0] ev;
      rv  = '0;
      map = 1'h1;
      clr = '0;
      ev  = '0;
      d   = q;

      d.wclk_p = write_port_clock;
      d.rclk_p = read_port_clock;
      d.rstb_p = read_strobe_n;

      if (wr_en) begin
         d.mem[write_address] = wword;
         d.wpf                = wfault;
      end
      if (q.pgen) begin
         d.wpf = 1'h0;
      end

      // The pipeline stage moves on read clock rises and holds between them; a control register write clears its valid flag.
      if (rd_edge && q.rmode == TPS_RM_PIPE) begin
         d.pipe_v = rd_acc;
         if (rd_acc) begin
            d.pipe   = rword;
            d.pipe_f = rfault;
         end
      end

      if (rd_upd) begin
         d.rdata = rd_new;
         d.rpf   = rd_new_f;
      end

      ev[TPS_STS_RPF] = rd_upd & rd_new_f;
      ev[TPS_STS_WPF] = wr_en & wfault;

      unique case (paddr)
         TPS_CTRL_OFS: begin
            rv[TPS_CTRL_RMODE +: TPS_RMODE_W] = q.rmode;
            rv[TPS_CTRL_WASYNC]               = q.wasync;
            rv[TPS_CTRL_ODD]                  = q.odd;
            rv[TPS_CTRL_PGEN]                 = q.pgen;
         end
         TPS_STATUS_OFS: begin
            rv[TPS_NEVT-1:0] = q.sts;
         end
         TPS_MASK_OFS: begin
            rv[TPS_NEVT-1:0] = q.msk;
         end
         default: begin
            map = 1'h0;
         end
      endcase

      // Zero wait states: the setup cycle loads the answer, the access cycle completes.
      unique case (q.ap)
         TPS_AP_IDLE: begin
            if (psel && !penable) begin
               d.ap      = TPS_AP_RESP;
               d.pready  = 1'h1;
               d.prdata  = rv;
               d.pslverr = ~map;
            end
         end
         TPS_AP_RESP: begin
            d.ap      = TPS_AP_IDLE;
            d.pready  = 1'h0;
            d.pslverr = 1'h0;
            d.prdata  = '0;
            if (psel && penable && pwrite && map) begin
               unique case (paddr)
                  TPS_CTRL_OFS: begin
                     d.rmode  = pwdata[TPS_CTRL_RMODE +: TPS_RMODE_W];
                     d.wasync = pwdata[TPS_CTRL_WASYNC];
                     d.odd    = pwdata[TPS_CTRL_ODD];
                     d.pgen   = pwdata[TPS_CTRL_PGEN];
                     d.pipe_v = 1'h0;
                  end
                  TPS_STATUS_OFS: begin
                     clr = pwdata[TPS_NEVT-1:0];
                  end
                  default: begin
                     d.msk = pwdata[TPS_NEVT-1:0];
                  end
               endcase
            end
         end
         default: begin
            d.ap = TPS_AP_IDLE;
         end
      endcase

      // A new event in the clearing cycle survives the write-one-to-clear.
      d.sts = (q.sts & ~clr) | ev;
      d.irq = |(d.sts & d.msk);

      // Reset leaves the array contents alone; every other register is defined.
      if (srst) begin
         d        = '0;
         d.mem    = q.mem;
         d.ap     = TPS_AP_IDLE;
         d.rmode  = TPS_RMODE_RST;
         d.wasync = TPS_WASYNC_RST;
         d.odd    = TPS_ODD_RST;
         d.pgen   = TPS_PGEN_RST;
         d.msk    = TPS_MASK_RST;
         d.wclk_p = write_port_clock;
         d.rclk_p = read_port_clock;
         d.rstb_p = read_strobe_n;
      end
   end

   always_ff @(posedge core_clk) begin
      q <= d;
   end

   assign read_data          = q.rdata;
   assign read_parity_fault  = q.rpf;
   assign write_parity_fault = q.wpf;
   assign irq                = q.irq;
   assign prdata             = q.prdata;
   assign pready             = q.pready;
   assign pslverr            = q.pslverr;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);

   bypass_data_a: assert property (
      (rd_upd && rd_hit && q.rmode != TPS_RM_PIPE) |=> (read_data == $past(wword)))
      else $error("Same-address read did not return the write word.");

   transp_update_a: assert property (
      (q.rmode == TPS_RM_TRANSP && rd_edge && rd_acc)
      |=> (read_data == $past(rword)) && (read_parity_fault == $past(rfault)))
      else $error("Transparent read did not update at the read edge.");

   pipe_capture_a: assert property (
      (q.rmode == TPS_RM_PIPE && rd_edge && rd_acc) |=> (q.pipe == $past(rword)) && q.pipe_v)
      else $error("Pipelined read stage missed the addressed word.");

   pipe_output_a: assert property (
      (q.rmode == TPS_RM_PIPE && rd_edge && q.pipe_v) |=> (read_data == $past(q.pipe, 1)))
      else $error("Pipelined output did not follow the second read edge.");

   wsync_edge_a: assert property (
      (!q.wasync && wr_en) |-> ($rose(write_port_clock) && !write_select_n))
      else $error("Synchronous write happened without a write clock rise.");

   rsync_edge_a: assert property (
      ($past(q.rmode) == TPS_RM_TRANSP && $changed(read_data)) |-> $past(rd_edge))
      else $error("Transparent read data moved without a read clock rise.");

   store_word_a: assert property (
      wr_en |=> (q.mem[$past(write_address)] == $past(wword)))
      else $error("Write word was not stored at its address.");

   gen_parity_a: assert property (
      (wr_en && q.pgen)
      |=> (q.mem[$past(write_address)][TPS_PAR_BIT] == ((^$past(wp_if.data)) ^ $past(q.odd))))
      else $error("Generated parity bit is wrong.");

   read_fault_a: assert property (
      (q.rmode == TPS_RM_ASYNC_A && rd_acc)
      ##1 (q.rmode == TPS_RM_ASYNC_A)[*1]
      |-> (read_parity_fault == ($past(rword[TPS_PAR_BIT]) != ((^$past(rp_if.data)) ^ $past(q.odd)))))
      else $error("Read parity fault does not match the read word.");

   write_fault_a: assert property (
      (wr_en && !q.pgen)
      |=> (write_parity_fault == ($past(write_data[TPS_PAR_BIT]) != ((^$past(wp_if.data)) ^ $past(q.odd)))))
      else $error("Write parity fault does not match the write data.");

   gen_no_fault_a: assert property (
      q.pgen |=> !write_parity_fault)
      else $error("Write parity fault raised while parity is generated.");

   strobe_read_a: assert property (
      (q.rmode == TPS_RM_ASYNC_S && rstb_fall && !read_select_n) |=> (read_data == $past(rword)))
      else $error("Strobe-timed read did not capture at the strobe fall.");

   rd_event_a: assert property (
      (rd_upd && rd_new_f) |=> q.sts[TPS_STS_RPF])
      else $error("Read parity fault did not set its status bit.");

   wr_event_a: assert property (
      (wr_en && wfault) |=> q.sts[TPS_STS_WPF])
      else $error("Write parity fault did not set its status bit.");

   read_hold_a: assert property (
      (q.rmode != TPS_RM_PIPE && (read_strobe_n || read_select_n)) |=> $stable(read_data))
      else $error("Read data moved without read strobe and select.");

   pipe_fault_a: assert property (
      (q.rmode == TPS_RM_PIPE && rd_edge && q.pipe_v) |=> (read_parity_fault == $past(q.pipe_f)))
      else $error("Pipelined parity fault did not follow the second read edge.");

endmodule
`default_nettype wire

// ### bench/tps_user_model.sv
// Fabric-side user logic model that drives the write and read ports of the memory block.
`timescale 1ns/1ps
`default_nettype none
module tps_user_model
   import tps_pkg::*;
(
   input  wire logic              core_clk,
   output logic                   write_port_clock,
   output logic                   read_port_clock,
   output logic      [TPS_AW-1:0] read_address,
   output logic                   read_select_n,
   output logic                   read_strobe_n,
   output logic      [TPS_AW-1:0] write_address,
   output logic                   write_select_n,
   output logic      [TPS_DW-1:0] write_data,
   output logic                   write_strobe_n,
   output logic                   look
);
   initial begin
      write_port_clock = 1'b0;
      read_port_clock  = 1'b0;
      read_address     = '0;
      read_select_n    = 1'b1;
      read_strobe_n    = 1'b1;
      write_address    = '0;
      write_select_n   = 1'b1;
      write_data       = '0;
      write_strobe_n   = 1'b1;
      look             = 1'b0;
   end

   // Write kind w: 1 clocked write, 2 select without strobe, 3 unclocked write. Read kind r: 1 read, 2 no strobe.
   task automatic acc(input logic [1:0] w, input logic [1:0] r, input logic lk, input logic [7:0] wa,
                      input logic [7:0] ra, input logic [8:0] d);
      @(posedge core_clk);
      write_port_clock <= (w == 2'h1 || w == 2'h2);
      write_select_n   <= (w == 2'h0);
      write_strobe_n   <= !(w == 2'h1 || w == 2'h3);
      write_address    <= wa;
      write_data       <= d;
      read_port_clock  <= (r != 2'h0);
      read_select_n    <= (r == 2'h0);
      read_strobe_n    <= (r != 2'h1);
      read_address     <= ra;
      @(posedge core_clk);
      // Released lines show the inverse so that a late sample cannot pass by luck.
      write_port_clock <= 1'b0;
      read_port_clock  <= 1'b0;
      write_select_n   <= 1'b1;
      write_strobe_n   <= 1'b1;
      read_select_n    <= 1'b1;
      read_strobe_n    <= 1'b1;
      write_address    <= ~wa;
      write_data       <= ~d;
      read_address     <= ~ra;
      look             <= lk;
      @(posedge core_clk);
      look <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ### bench/two_port_sram_block_with_parity_tb.sv
// Self-checking testbench for the two-port parity memory block.
`timescale 1ns/1ps
`default_nettype none
module two_port_sram_block_with_parity_tb;
   import tps_pkg::*;
   logic               core_clk, srst, look;
   logic               write_port_clock, read_port_clock, read_select_n, read_strobe_n;
   logic               write_select_n, write_strobe_n;
   logic [TPS_AW-1:0]  read_address, write_address, a;
   logic [TPS_DW-1:0]  write_data, read_data, d, pv;
   logic               read_parity_fault, write_parity_fault, irq;
   logic               psel, penable, pwrite, pready, pslverr;
   logic [TPS_PAW-1:0] paddr;
   logic [TPS_PDW-1:0] pwdata, prdata;
   logic [32:0]        exp_q[$];
   int                 err_count, check_count, seed;

   tps_sram_core i_dut (.core_clk, .srst, .write_port_clock, .read_port_clock, .read_address, .read_select_n,
      .read_strobe_n, .write_address, .write_select_n, .write_data, .write_strobe_n, .read_data,
      .read_parity_fault, .write_parity_fault, .irq, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr);
   tps_user_model i_user (.core_clk, .write_port_clock, .read_port_clock, .read_address, .read_select_n,
      .read_strobe_n, .write_address, .write_select_n, .write_data, .write_strobe_n, .look);

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   function automatic logic par(input logic [7:0] v, input logic odd);
      return odd ? ~^v : ^v;
   endfunction

   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // A result with nothing queued is a mismatch even when it is unknown.
   task automatic pop_chk(input logic [32:0] got);
      if (exp_q.size() == 0) begin
         check_count++;
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, 33'h0);
      end else begin
         chk(got, exp_q.pop_front());
      end
   endtask

   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // The slave's latency is not assumed; the wait ends at pready or after 16 cycles, whichever comes first.
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd, input logic [32:0] e);
      int n;
      exp_q.push_back(e);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         err_count++;
         give_verdict();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic irq_chk(input logic e);
      repeat (2) @(posedge core_clk);
      chk({32'h0, irq}, {32'h0, e});
   endtask

   always @(posedge core_clk) begin
      if (look === 1'b1) pop_chk({23'h0, read_parity_fault, read_data});
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) pop_chk(pwrite ? {pslverr, 32'h0} : {pslverr, prdata});
   end

   initial begin
      seed = 81910;
      err_count = 0;
      check_count = 0;
      srst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (10) @(posedge core_clk);
      srst <= 1'b0;
      apb(0, TPS_CTRL_OFS, 0, 0);
      apb(0, TPS_STATUS_OFS, 0, 0);
      apb(0, TPS_MASK_OFS, 0, 0);
      apb(0, 8'h0C, 0, {1'b1, 32'h0});
      apb(1, 8'h0C, 32'hFFFFFFFF, {1'b1, 32'h0});
      apb(0, TPS_CTRL_OFS, 0, 0);
      $display("Test registers done");
      for (int m = 0; m < 4; m++) begin
         apb(1, TPS_CTRL_OFS, 32'(m), 0);
         for (int i = 0; i < 5; i++) begin
            a = 8'($random(seed));
            d[7:0] = 8'($random(seed));
            d[8] = par(d[7:0], 1'b0);
            i_user.acc(1, 0, 0, a, 0, d);
            if (m != 1 || i > 0) exp_q.push_back({24'h0, (m == 1) ? pv : d});
            i_user.acc(0, 1, (m != 1 || i > 0), 0, a, 0);
            pv = d;
         end
         if (m == 1) begin
            exp_q.push_back({24'h0, pv});
            i_user.acc(0, 1, 1, 0, a, 0);
         end
         $display("Test read mode %0d done", m);
      end
      for (int k = 0; k < 4; k++) begin
         apb(1, TPS_CTRL_OFS, {27'h0, k[1], k[0], 3'h0}, 0);
         a = 8'(k * 85);
         d[7:0] = 8'($random(seed));
         d[8] = ~par(d[7:0], k[0]);
         i_user.acc(1, 0, 0, a, 0, d);
         chk({32'h0, write_parity_fault}, {32'h0, ~k[1]});
         exp_q.push_back({23'h0, ~k[1], k[1] ? {~d[8], d[7:0]} : d});
         i_user.acc(0, 1, 1, 0, a, 0);
      end
      $display("Test parity done");
      apb(0, TPS_STATUS_OFS, 0, {31'h0, 2'h3});
      irq_chk(1'b0);
      apb(1, TPS_MASK_OFS, 32'h2, 0);
      irq_chk(1'b1);
      apb(1, TPS_STATUS_OFS, 32'h2, 0);
      irq_chk(1'b0);
      apb(0, TPS_STATUS_OFS, 0, {31'h0, 2'h1});
      apb(1, TPS_MASK_OFS, 32'h1, 0);
      irq_chk(1'b1);
      apb(1, TPS_STATUS_OFS, 32'h1, 0);
      irq_chk(1'b0);
      $display("Test interrupt done");
      apb(1, TPS_CTRL_OFS, 32'h4, 0);
      i_user.acc(3, 0, 0, 8'hFF, 0, 9'h0FF);
      exp_q.push_back({24'h0, 9'h0FF});
      i_user.acc(0, 1, 1, 0, 8'hFF, 0);
      apb(1, TPS_CTRL_OFS, 0, 0);
      exp_q.push_back({24'h0, 9'h05A});
      i_user.acc(1, 1, 1, 8'h3C, 8'h3C, 9'h05A);
      i_user.acc(2, 0, 0, 8'h3C, 0, 9'h1A5);
      exp_q.push_back({24'h0, 9'h05A});
      i_user.acc(0, 2, 1, 0, 8'hFF, 0);
      exp_q.push_back({24'h0, 9'h05A});
      i_user.acc(0, 1, 1, 0, 8'h3C, 0);
      $display("Test bypass and refusals done");
      give_verdict();
   end
endmodule
`default_nettype wire
